// *** rtl/cgactl_regs.vh ***
// Port addresses, field positions, reset values and colour codes
`ifndef CGACTL_REGS_VH
`define CGACTL_REGS_VH

// Host I/O ports (10-bit channel address)
`define CGACTL_PORT_MODE       10'h3D8
`define CGACTL_PORT_PALETTE    10'h3D9
`define CGACTL_PORT_STATUS     10'h3DA
`define CGACTL_PORT_LPEN_CLR   10'h3DB
`define CGACTL_PORT_LPEN_SET   10'h3DC

// Register widths and reset values
`define CGACTL_MODE_W          6
`define CGACTL_PAL_W           6
`define CGACTL_STAT_W          4
`define CGACTL_MODE_RST        6'h00
`define CGACTL_PAL_RST         6'h00
`define CGACTL_WO_READ_VAL     8'h00

// Mode field positions
`define CGACTL_MODE_80COL      0
`define CGACTL_MODE_GRAPHICS   1
`define CGACTL_MODE_BW         2
`define CGACTL_MODE_VIDEO_EN   3
`define CGACTL_MODE_HIRES      4
`define CGACTL_MODE_BLINK      5

// Palette field positions
`define CGACTL_PAL_COLOR_LSB   0
`define CGACTL_PAL_COLOR_MSB   3
`define CGACTL_PAL_INTENSE     4
`define CGACTL_PAL_SET         5

// Status field positions
`define CGACTL_STAT_ACCESS_OK  0
`define CGACTL_STAT_LPEN_TRIG  1
`define CGACTL_STAT_LPEN_SW    2
`define CGACTL_STAT_VRETRACE   3

// Display memory window (16K bytes at B8000)
`define CGACTL_VRAM_BASE       20'hB8000
`define CGACTL_VRAM_AW         14

// IRGB colour codes
`define CGACTL_RGBI_BLACK      4'h0
`define CGACTL_RGBI_GREEN      4'h2
`define CGACTL_RGBI_CYAN       4'h3
`define CGACTL_RGBI_RED        4'h4
`define CGACTL_RGBI_MAGENTA    4'h5
`define CGACTL_RGBI_BROWN      4'h6
`define CGACTL_RGBI_WHITE      4'h7

`endif

// *** rtl/cgactl_vram.v ***
// Dual-port display memory: host port and display fetch port
`timescale 1ns/1ps
module cgactl_vram #(
  parameter AW = 14,
  parameter DW = 8
) (
  input  wire          clk_sys_i,   // System clock
  input  wire          host_we_i,   // Host write strobe
  input  wire [AW-1:0] host_addr_i, // Host byte address
  input  wire [DW-1:0] host_wdata_i,// Host write data
  output reg  [DW-1:0] host_rdata_o,// Host read data, one cycle later
  input  wire [AW-1:0] disp_addr_i, // Display fetch address
  output reg  [DW-1:0] disp_rdata_o // Display fetch data, one cycle later
);

  // No parity bits are stored
  reg [DW-1:0] mem_arr [0:(1<<AW)-1];

  always @(posedge clk_sys_i) begin
    if (host_we_i) begin
      mem_arr[host_addr_i] <= host_wdata_i;
    end
    host_rdata_o <= mem_arr[host_addr_i];
    disp_rdata_o <= mem_arr[disp_addr_i];
  end

endmodule // cgactl_vram

// *** rtl/cgactl_palette.v ***
// Colour lookup from mode, palette and pixel or text attribute
`timescale 1ns/1ps
`include "cgactl_regs.vh"
module cgactl_palette (
  input  wire [5:0] mode_i,      // Mode register
  input  wire [5:0] pal_i,       // Palette register
  input  wire [1:0] code_i,      // Graphics pixel code
  input  wire       txt_dot_i,   // Glyph dot in text mode
  input  wire [7:0] txt_attr_i,  // Text attribute byte
  input  wire       blink_ph_i,  // Blink phase
  input  wire       border_i,    // Beam is in the border
  output reg  [3:0] rgbi_o       // Resulting IRGB colour
);

  wire [3:0] pal_col = pal_i[`CGACTL_PAL_COLOR_MSB:`CGACTL_PAL_COLOR_LSB];
  wire       gfx     = mode_i[`CGACTL_MODE_GRAPHICS];
  wire       hires   = mode_i[`CGACTL_MODE_HIRES];
  reg  [3:0] bg;
  reg  [3:0] set_col;

  always @* begin
    rgbi_o  = `CGACTL_RGBI_BLACK;
    bg      = `CGACTL_RGBI_BLACK;
    set_col = 4'h0;
    if (border_i) begin
      // Border carries the palette colour in 40-column text and in 320x200 graphics, black otherwise
      if (!gfx && !mode_i[`CGACTL_MODE_80COL])
        rgbi_o = pal_col;
      else if (gfx && !hires)
        rgbi_o = pal_col;
    end else if (gfx && hires) begin
      rgbi_o = code_i[1] ? pal_col : `CGACTL_RGBI_BLACK;
    end else if (gfx) begin
      if (pal_i[`CGACTL_PAL_SET]) begin
        case (code_i)
          2'b01:   set_col = `CGACTL_RGBI_CYAN;
          2'b10:   set_col = `CGACTL_RGBI_MAGENTA;
          default: set_col = `CGACTL_RGBI_WHITE;
        endcase
      end else begin
        case (code_i)
          2'b01:   set_col = `CGACTL_RGBI_GREEN;
          2'b10:   set_col = `CGACTL_RGBI_RED;
          default: set_col = `CGACTL_RGBI_BROWN;
        endcase
      end
      if (code_i == 2'b00)
        rgbi_o = pal_col;
      else
        rgbi_o = {pal_i[`CGACTL_PAL_INTENSE], set_col[2:0]};
    end else begin
      if (mode_i[`CGACTL_MODE_BLINK]) begin
        bg = {pal_i[`CGACTL_PAL_INTENSE], txt_attr_i[6:4]};
        if (txt_dot_i && !(txt_attr_i[7] && blink_ph_i))
          rgbi_o = txt_attr_i[3:0];
        else
          rgbi_o = bg;
      end else begin
        bg = txt_attr_i[7:4];
        rgbi_o = txt_dot_i ? txt_attr_i[3:0] : bg;
      end
    end
  end

endmodule // cgactl_palette

// *** rtl/cgactl_top.v ***
// Control, status, light-pen latch and pixel path of the display adapter
`timescale 1ns/1ps
`include "cgactl_regs.vh"
module cgactl_top #(
  parameter VRAM_AW = `CGACTL_VRAM_AW
) (
  input  wire               clk_sys_i,      // System clock, 200 MHz
  input  wire               reset_i,        // Synchronous reset, high
  // Host I/O channel
  input  wire [9:0]         io_addr_i,      // I/O port address
  input  wire               io_wr_i,        // I/O write strobe
  input  wire               io_rd_i,        // I/O read strobe
  input  wire [7:0]         io_wdata_i,     // I/O write data
  output reg  [7:0]         io_rdata_o,     // I/O read data
  output reg                io_rd_hit_o,    // Read claimed by this block
  // Host memory channel
  input  wire [19:0]        mem_addr_i,     // Memory byte address
  input  wire               mem_wr_i,       // Memory write strobe
  input  wire               mem_rd_i,       // Memory read strobe
  input  wire [7:0]         mem_wdata_i,    // Memory write data
  output wire [7:0]         mem_rdata_o,    // Memory read data
  output reg                mem_rd_hit_o,   // Memory read data valid
  // Timing controller and pen
  input  wire               disp_active_i,  // Beam in active area
  input  wire               vretrace_i,     // Vertical retrace
  input  wire               border_i,       // Beam in border
  input  wire               lpen_trig_i,    // Light-pen trigger
  input  wire               lpen_sw_closed_i, // Pen switch closed
  // Display fetch
  input  wire [VRAM_AW-1:0] fetch_addr_i,   // Fetch address
  input  wire               fetch_load_i,   // Load fetched byte
  input  wire               pixel_step_i,   // Advance one pixel
  input  wire               txt_dot_i,      // Glyph dot in text
  input  wire [7:0]         txt_attr_i,     // Text attribute
  input  wire               blink_ph_i,     // Blink phase
  // Video outputs
  output reg  [3:0]         rgbi_o,         // IRGB pixel colour
  output wire               mono_o,         // Black-and-white mode
  output wire               video_en_o,     // Video enable
  output wire               gfx_o,          // Graphics mode
  output wire               hires_o,        // 640x200 mode
  output wire               col80_o         // 80-column text
);

  localparam [VRAM_AW-1:0] VRAM_TOP = {VRAM_AW{1'b1}};

  // Shift-register pixel states
  localparam [2:0] PX_IDLE = 3'b001;
  localparam [2:0] PX_WAIT = 3'b010;
  localparam [2:0] PX_RUN  = 3'b100;

  reg  [5:0]         mode_reg;
  reg  [5:0]         mode_next;
  reg  [5:0]         pal_reg;
  reg  [5:0]         pal_next;
  reg                lpen_reg;
  reg                lpen_next;
  reg                lpen_prev_reg;
  reg  [7:0]         io_rdata_next;
  reg                io_rd_hit_next;
  reg  [2:0]         px_state_reg;
  reg  [2:0]         px_state_next;
  reg  [7:0]         shift_reg;
  reg  [7:0]         shift_next;
  reg  [3:0]         rgbi_next;
  wire [3:0]         status_bits;
  wire               vram_sel;
  wire [19:0]        vram_off;
  wire [7:0]         fetch_data;
  wire [1:0]         pix_code;
  wire [3:0]         pal_rgbi;

  // Strip bits 6 and 7 of written data
  function [5:0] cgactl_low6;
    input [7:0] d;
    begin
      cgactl_low6 = d[5:0];
    end
  endfunction

  function cgactl_port_hit;
    input [9:0] addr;
    input [9:0] port;
    begin
      cgactl_port_hit = (addr == port);
    end
  endfunction

  assign mono_o     = mode_reg[`CGACTL_MODE_BW];
  assign video_en_o = mode_reg[`CGACTL_MODE_VIDEO_EN];
  assign gfx_o      = mode_reg[`CGACTL_MODE_GRAPHICS];
  assign hires_o    = mode_reg[`CGACTL_MODE_HIRES];
  assign col80_o    = mode_reg[`CGACTL_MODE_80COL];

  // Register writes
  always @* begin
    mode_next = mode_reg;
    pal_next  = pal_reg;
    if (io_wr_i && cgactl_port_hit(io_addr_i, `CGACTL_PORT_MODE))
      mode_next = cgactl_low6(io_wdata_i);
    if (io_wr_i && cgactl_port_hit(io_addr_i, `CGACTL_PORT_PALETTE))
      pal_next = cgactl_low6(io_wdata_i);
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_reg <= `CGACTL_MODE_RST;
      pal_reg  <= `CGACTL_PAL_RST;
    end else begin
      mode_reg <= mode_next;
      pal_reg  <= pal_next;
    end
  end

  // Light-pen latch: a new edge wins over a clear in the same cycle
  always @* begin
    lpen_next = lpen_reg;
    if (io_wr_i && cgactl_port_hit(io_addr_i, `CGACTL_PORT_LPEN_CLR))
      lpen_next = 1'b0;
    if (io_wr_i && cgactl_port_hit(io_addr_i, `CGACTL_PORT_LPEN_SET))
      lpen_next = 1'b1;
    if (lpen_trig_i && !lpen_prev_reg)
      lpen_next = 1'b1;
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      lpen_reg      <= 1'b0;
      lpen_prev_reg <= 1'b1;
    end else begin
      lpen_reg      <= lpen_next;
      lpen_prev_reg <= lpen_trig_i;
    end
  end

  // Status bits are sampled live on the read
  assign status_bits[`CGACTL_STAT_ACCESS_OK] = ~disp_active_i;
  assign status_bits[`CGACTL_STAT_LPEN_TRIG] = lpen_reg;
  assign status_bits[`CGACTL_STAT_LPEN_SW]   = ~lpen_sw_closed_i;
  assign status_bits[`CGACTL_STAT_VRETRACE]  = vretrace_i;

  // I/O read answer, one cycle after the strobe
  always @* begin
    io_rdata_next  = `CGACTL_WO_READ_VAL;
    io_rd_hit_next = 1'b0;
    if (io_rd_i) begin
      if (cgactl_port_hit(io_addr_i, `CGACTL_PORT_STATUS)) begin
        io_rdata_next  = {4'h0, status_bits};
        io_rd_hit_next = 1'b1;
      end else if (cgactl_port_hit(io_addr_i, `CGACTL_PORT_MODE) ||
                   cgactl_port_hit(io_addr_i, `CGACTL_PORT_PALETTE)) begin
        // Write-only ports answer with a fixed value, never contents
        io_rdata_next  = `CGACTL_WO_READ_VAL;
        io_rd_hit_next = 1'b1;
      end
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      io_rdata_o  <= 8'h00;
      io_rd_hit_o <= 1'b0;
    end else begin
      io_rdata_o  <= io_rdata_next;
      io_rd_hit_o <= io_rd_hit_next;
    end
  end

  // Display memory window decode
  assign vram_off = mem_addr_i - `CGACTL_VRAM_BASE;
  assign vram_sel = (mem_addr_i >= `CGACTL_VRAM_BASE) &&
                    (vram_off[19:VRAM_AW] == {(20-VRAM_AW){1'b0}});

  always @(posedge clk_sys_i) begin
    if (reset_i)
      mem_rd_hit_o <= 1'b0;
    else
      mem_rd_hit_o <= mem_rd_i && vram_sel;
  end

  cgactl_vram #(
    .AW (VRAM_AW),
    .DW (8)
  ) u_vram (
    .clk_sys_i    (clk_sys_i),
    .host_we_i    (mem_wr_i && vram_sel),
    .host_addr_i  (vram_off[VRAM_AW-1:0]),
    .host_wdata_i (mem_wdata_i),
    .host_rdata_o (mem_rdata_o),
    .disp_addr_i  (fetch_addr_i & VRAM_TOP),
    .disp_rdata_o (fetch_data)
  );

  // Pixel shifter; fetched data arrives one cycle after the load strobe
  always @* begin
    px_state_next = px_state_reg;
    shift_next    = shift_reg;
    case (px_state_reg)
      PX_IDLE: begin
        if (fetch_load_i)
          px_state_next = PX_WAIT;
      end
      PX_WAIT: begin
        shift_next    = fetch_data;
        px_state_next = fetch_load_i ? PX_WAIT : PX_RUN;
      end
      PX_RUN: begin
        if (fetch_load_i)
          px_state_next = PX_WAIT;
        if (pixel_step_i) begin
          if (mode_reg[`CGACTL_MODE_HIRES])
            shift_next = {shift_reg[6:0], 1'b0};
          else
            shift_next = {shift_reg[5:0], 2'b00};
        end
      end
      default: begin
        px_state_next = PX_IDLE;
      end
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      px_state_reg <= PX_IDLE;
      shift_reg    <= 8'h00;
    end else begin
      px_state_reg <= px_state_next;
      shift_reg    <= shift_next;
    end
  end

  // Hi-res uses one bit per pixel, taken from the top
  assign pix_code = mode_reg[`CGACTL_MODE_HIRES] ?
                    {shift_reg[7], shift_reg[7]} : shift_reg[7:6];

  cgactl_palette u_palette (
    .mode_i     (mode_reg),
    .pal_i      (pal_reg),
    .code_i     (pix_code),
    .txt_dot_i  (txt_dot_i),
    .txt_attr_i (txt_attr_i),
    .blink_ph_i (blink_ph_i),
    .border_i   (border_i),
    .rgbi_o     (pal_rgbi)
  );

  // Blanked whenever video is disabled, so mode changes stay invisible
  always @* begin
    if (mode_reg[`CGACTL_MODE_VIDEO_EN])
      rgbi_next = pal_rgbi;
    else
      rgbi_next = `CGACTL_RGBI_BLACK;
  end

  always @(posedge clk_sys_i) begin
    if (reset_i)
      rgbi_o <= `CGACTL_RGBI_BLACK;
    else
      rgbi_o <= rgbi_next;
  end

endmodule // cgactl_top

// *** dv/cgactl_regs_checker.sv ***
// Concurrent checks on the adapter control block ports
`timescale 1ns/1ps
module cgactl_regs_checker (
  input wire        clk_sys_i,        // Clock
  input wire        reset_i,          // Reset
  input wire [9:0]  io_addr_i,        // Port
  input wire        io_wr_i,          // Write
  input wire        io_rd_i,          // Read
  input wire [7:0]  io_wdata_i,       // Wdata
  input wire [7:0]  io_rdata_o,       // Rdata
  input wire        io_rd_hit_o,      // Claimed
  input wire [19:0] mem_addr_i,       // Maddr
  input wire        mem_rd_i,         // Mread
  input wire        mem_rd_hit_o,     // Mvalid
  input wire        disp_active_i,    // Active
  input wire        vretrace_i,       // Retrace
  input wire        lpen_trig_i,      // Trigger
  input wire        lpen_sw_closed_i, // Switch
  input wire [3:0]  rgbi_o,           // Colour
  input wire        mono_o,           // Mono
  input wire        video_en_o,       // Video
  input wire        gfx_o,            // Gfx
  input wire        hires_o,          // Hires
  input wire        col80_o           // Cols
);
  wire [4:0] mode_w  = {hires_o, video_en_o, mono_o, gfx_o, col80_o};
  wire       rd_stat = io_rd_i && io_addr_i == 10'h3DA;
  wire       rd_wo   = io_rd_i && io_addr_i[9:1] == 9'h1EC;
  wire       rd_none = io_rd_i && !rd_stat && !rd_wo;
  wire       wr_mode = io_wr_i && io_addr_i == 10'h3D8;
  wire       wr_clr  = io_wr_i && io_addr_i == 10'h3DB;
  wire       wr_set  = io_wr_i && io_addr_i == 10'h3DC;
  wire       win_rd  = mem_rd_i && mem_addr_i[19:14] == 6'h2E;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_status_read:
    assert property (rd_stat |=> io_rd_hit_o && io_rdata_o == {4'h0,
      $past(vretrace_i), !$past(lpen_sw_closed_i), io_rdata_o[1],
      !$past(disp_active_i)}) else $error("status read wrong");
  a_wo_read:
    assert property (rd_wo |=> io_rd_hit_o && io_rdata_o == 8'h00)
      else $error("write-only port readable");
  a_unmapped_read:
    assert property (rd_none |=> !io_rd_hit_o && io_rdata_o == 8'h00)
      else $error("unmapped read claimed");
  a_mode_load:
    assert property (wr_mode |=> mode_w == $past(io_wdata_i[4:0]))
      else $error("mode not loaded");
  a_mode_hold:
    assert property (!wr_mode |=> $stable(mode_w))
      else $error("mode changed without write");
  a_video_gate:
    assert property (!video_en_o |=> rgbi_o == 4'h0)
      else $error("colour with video off");
  a_pen_preset:
    assert property (wr_set ##2 rd_stat |=> io_rdata_o[1])
      else $error("pen latch not preset");
  a_pen_clear:
    assert property (wr_clr && !$rose(lpen_trig_i) ##1
      !$rose(lpen_trig_i) && !wr_set ##1 rd_stat |=> !io_rdata_o[1])
      else $error("pen latch not cleared");
  a_mem_hit:
    assert property (win_rd |=> mem_rd_hit_o)
      else $error("window read not answered");

  c_pen: cover property (wr_set ##2 rd_stat);
  c_gfx: cover property (gfx_o && video_en_o && !hires_o);
  c_mem: cover property (win_rd);
endmodule // cgactl_regs_checker

// *** dv/cgactl_host_model.sv ***
// Host processor model issuing I/O and memory cycles
`timescale 1ns/1ps
module cgactl_host_model (
  input  wire        clk_sys_i,   // Clock
  output reg  [9:0]  io_addr_o,   // Port
  output reg         io_wr_o,     // Write
  output reg         io_rd_o,     // Read
  output reg  [7:0]  io_wdata_o,  // Wdata
  input  wire [7:0]  io_rdata_i,  // Rdata
  input  wire        io_rd_hit_i, // Claimed
  output reg  [19:0] mem_addr_o,  // Maddr
  output reg         mem_wr_o,    // Mwrite
  output reg         mem_rd_o,    // Mread
  output reg  [7:0]  mem_wdata_o, // Mwdata
  input  wire [7:0]  mem_rdata_i, // Mrdata
  input  wire        mem_rd_hit_i // Mvalid
);
  initial begin
    {io_addr_o, io_wr_o, io_rd_o, io_wdata_o} = 20'h00000;
    {mem_addr_o, mem_wr_o, mem_rd_o, mem_wdata_o} = 30'h00000000;
  end
  // Released lines carry the inverse so stale values cannot match
  task io(input w, input [9:0] a, input [7:0] d,
          output [7:0] q, output h);
    @(negedge clk_sys_i);
    {io_addr_o, io_wdata_o, io_wr_o, io_rd_o} = {a, d, w, !w};
    @(negedge clk_sys_i);
    {io_wr_o, io_rd_o} = 2'b00;
    q = io_rdata_i;
    h = io_rd_hit_i;
    {io_addr_o, io_wdata_o} = ~{a, d};
  endtask
  task mem(input w, input [19:0] a, input [7:0] d,
           output [7:0] q, output h);
    @(negedge clk_sys_i);
    {mem_addr_o, mem_wdata_o, mem_wr_o, mem_rd_o} = {a, d, w, !w};
    @(negedge clk_sys_i);
    {mem_wr_o, mem_rd_o} = 2'b00;
    q = mem_rdata_i;
    h = mem_rd_hit_i;
    {mem_addr_o, mem_wdata_o} = ~{a, d};
  endtask
  // Video stays off while the mode is rebuilt, re-enabled last
  task mode_change(input [7:0] m, input [7:0] p);
    reg [7:0] q;
    reg       h;
    io(1'b1, 10'h3D8, m & 8'hF7, q, h);
    io(1'b1, 10'h3D9, p, q, h);
    io(1'b1, 10'h3D8, m, q, h);
  endtask
endmodule // cgactl_host_model

// *** dv/cgactl_regs_bench.sv ***
// Self-checking bench for the adapter control block
`timescale 1ns/1ps
module cgactl_regs_bench;
  reg         clk_sys_i = 0, reset_i = 1;
  wire [9:0]  io_addr_i;
  wire [7:0]  io_wdata_i, io_rdata_o, mem_wdata_i, mem_rdata_o;
  wire        io_wr_i, io_rd_i, io_rd_hit_o;
  wire [19:0] mem_addr_i;
  wire        mem_wr_i, mem_rd_i, mem_rd_hit_o;
  reg         disp_active_i = 0, vretrace_i = 0, border_i = 0;
  reg         lpen_trig_i = 0, lpen_sw_closed_i = 0;
  reg  [13:0] fetch_addr_i = 14'h0000;
  reg         fetch_load_i = 0, pixel_step_i = 0;
  reg         txt_dot_i = 0, blink_ph_i = 0;
  reg  [7:0]  txt_attr_i = 8'h00;
  wire [3:0]  rgbi_o;
  wire        mono_o, video_en_o, gfx_o, hires_o, col80_o;
  wire [4:0]  mode_w = {hires_o, video_en_o, mono_o, gfx_o, col80_o};
  reg  [7:0]  q;
  reg         h;
  int         fail_count = 0, total_checks = 0, cyc = 0;

  cgactl_top u_cgactl_top (.clk_sys_i, .reset_i, .io_addr_i, .io_wr_i,
    .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rd_hit_o, .mem_addr_i,
    .mem_wr_i, .mem_rd_i, .mem_wdata_i, .mem_rdata_o, .mem_rd_hit_o,
    .disp_active_i, .vretrace_i, .border_i, .lpen_trig_i,
    .lpen_sw_closed_i, .fetch_addr_i, .fetch_load_i, .pixel_step_i,
    .txt_dot_i, .txt_attr_i, .blink_ph_i, .rgbi_o,
    .mono_o, .video_en_o, .gfx_o, .hires_o, .col80_o);
  cgactl_host_model u_cgactl_host_model (.clk_sys_i,
    .io_addr_o(io_addr_i), .io_wr_o(io_wr_i), .io_rd_o(io_rd_i),
    .io_wdata_o(io_wdata_i), .io_rdata_i(io_rdata_o),
    .io_rd_hit_i(io_rd_hit_o), .mem_addr_o(mem_addr_i),
    .mem_wr_o(mem_wr_i), .mem_rd_o(mem_rd_i), .mem_wdata_o(mem_wdata_i),
    .mem_rdata_i(mem_rdata_o), .mem_rd_hit_i(mem_rd_hit_o));

  initial forever #2.5 clk_sys_i = ~clk_sys_i;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    u_cgactl_host_model.io(1'b1, a, d, q, h);
  endtask
  task rd_chk(input [9:0] a, input [7:0] eq, input eh);
    u_cgactl_host_model.io(1'b0, a, 8'h00, q, h);
    chk({h, q}, {eh, eq});
  endtask
  task conclude;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task t_mode;
    logic [7:0] mv [0:3] = '{8'hED, 8'h1E, 8'h15, 8'h00};
    for (int i = 0; i < 4; i++) begin
      wr(10'h3D8, mv[i]);
      chk(mode_w, mv[i][4:0]);
    end
    wr(10'h3DD, 8'h1F);
    chk(mode_w, 5'h00);
    wr(10'h3D9, 8'h3F);
    rd_chk(10'h3D8, 8'h00, 1'b1);
    rd_chk(10'h3D9, 8'h00, 1'b1);
    rd_chk(10'h3DD, 8'h00, 1'b0);
    $display("mode test done");
  endtask
  task t_status;
    for (int i = 0; i < 8; i++) begin
      {vretrace_i, lpen_sw_closed_i, disp_active_i} = i[2:0];
      rd_chk(10'h3DA, {4'h0, i[2], !i[1], 1'b0, !i[0]}, 1'b1);
    end
    $display("status test done");
  endtask
  task t_pen;
    {vretrace_i, lpen_sw_closed_i, disp_active_i} = 3'b000;
    lpen_trig_i = 1;
    @(negedge clk_sys_i);
    lpen_trig_i = 0;
    rd_chk(10'h3DA, 8'h07, 1'b1);
    wr(10'h3DB, 8'h5A);
    rd_chk(10'h3DA, 8'h05, 1'b1);
    wr(10'h3DC, 8'h00);
    rd_chk(10'h3DA, 8'h07, 1'b1);
    wr(10'h3DB, 8'hFF);
    rd_chk(10'h3DA, 8'h05, 1'b1);
    $display("pen test done");
  endtask
  task t_mem;
    u_cgactl_host_model.mem(1'b1, 20'hB8005, 8'h5A, q, h);
    u_cgactl_host_model.mem(1'b1, 20'hBBFFF, 8'hA5, q, h);
    u_cgactl_host_model.mem(1'b0, 20'hB8005, 8'h00, q, h);
    chk({h, q}, 9'h15A);
    u_cgactl_host_model.mem(1'b0, 20'hBBFFF, 8'h00, q, h);
    chk({h, q}, 9'h1A5);
    u_cgactl_host_model.mem(1'b0, 20'hBC000, 8'h00, q, h);
    chk(h, 1'b0);
    $display("memory test done");
  endtask
  // Four pixels of one fetched byte, one step apart
  task px(input [7:0] b, input [15:0] e);
    u_cgactl_host_model.mem(1'b1, 20'hB8000, b, q, h);
    fetch_load_i = 1;
    @(negedge clk_sys_i);
    fetch_load_i = 0;
    repeat (3) @(negedge clk_sys_i);
    for (int k = 0; k < 4; k++) begin
      chk(rgbi_o, e[15-4*k -: 4]);
      pixel_step_i = 1;
      @(negedge clk_sys_i);
      pixel_step_i = 0;
      repeat (3) @(negedge clk_sys_i);
    end
  endtask
  task t_pixels;
    for (int s = 0; s < 2; s++)
      for (int i = 0; i < 2; i++) begin
        u_cgactl_host_model.mode_change(8'h0A, {2'b00, s[0], i[0], 4'h9});
        px(8'h1B, {4'h9, i[0], s ? 3'h3 : 3'h2, i[0], s ? 3'h5 : 3'h4,
           i[0], s ? 3'h7 : 3'h6});
      end
    u_cgactl_host_model.mode_change(8'h1E, 8'h0C);
    px(8'hA0, 16'hC0C0);
    $display("pixel test done");
  endtask
  // Text colour waits for the registered output to settle
  task tx_chk(input [3:0] e);
    repeat (2) @(negedge clk_sys_i);
    chk(rgbi_o, e);
  endtask
  task t_text;
    txt_attr_i = 8'h43;
    txt_dot_i = 1;
    u_cgactl_host_model.mode_change(8'h29, 8'h10);
    tx_chk(4'h3);
    txt_dot_i = 0;
    tx_chk(4'hC);
    txt_attr_i = 8'hC3;
    txt_dot_i = 1;
    blink_ph_i = 1;
    tx_chk(4'hC);
    blink_ph_i = 0;
    txt_attr_i = 8'h43;
    txt_dot_i = 0;
    u_cgactl_host_model.mode_change(8'h09, 8'h06);
    tx_chk(4'h4);
    border_i = 1;
    tx_chk(4'h0);
    u_cgactl_host_model.mode_change(8'h08, 8'h06);
    tx_chk(4'h6);
    border_i = 0;
    $display("text test done");
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude;
    end
  end

  initial begin
    repeat (3) @(negedge clk_sys_i);
    reset_i = 0;
    chk({mode_w, rgbi_o}, 9'h000);
    t_mode;
    t_status;
    t_pen;
    t_mem;
    t_pixels;
    t_text;
    conclude;
  end
endmodule // cgactl_regs_bench

bind cgactl_top cgactl_regs_checker u_cgactl_regs_checker (.clk_sys_i,
  .reset_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
  .io_rd_hit_o, .mem_addr_i, .mem_rd_i, .mem_rd_hit_o, .disp_active_i,
  .vretrace_i, .lpen_trig_i, .lpen_sw_closed_i, .rgbi_o, .mono_o,
  .video_en_o, .gfx_o, .hires_o, .col80_o);
